// ==== rtl/mscp_port.v ====
// Notes on behaviour
// - data line open-drain; clock, ready one-way
// - conversion done raises ready until read
// - accepted read address drops ready
// - write is address plus four control bytes
// - read is address plus ten result bytes
// - address header 110010, beeper bit, direction bit
// - valid write address accepted at any time
// - control byte one: assist, function, range
// - control byte two: reversed tone, rate; freq
// - control byte three: coupling, source, filter, resistance
// - control byte four: amplifier config, adapter mode
// - result byte one: signs, battery, divider, alarm
// - result byte two: flags, slow bits 0-2
// - slow result LSB first in bytes 3-4
// - results are plain binary magnitudes
// - ordinary modes: ready on each fast conversion
// - frequency, capacitance: ready on slow or aux3
// - sign bits mark negative results
// - write address alone updates only beeper; read address also drops ready
`timescale 1ns/100ps
`default_nettype none
`include "mscp_regs.vh"

module mscp_port #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clock,
  input wire rst_n,
  input wire serial_clk_i,
  input wire serial_io_line_i,
  output wire serial_io_line_o,
  output wire serial_io_line_oe,
  output wire result_ready,
  input wire fast_done,
  input wire slow_done,
  input wire aux3_done,
  input wire slow_sign,
  input wire fast_sign,
  input wire [1:0] battery_level,
  input wire divider_ind_low,
  input wire divider_ind_high,
  input wire alarm_flag,
  input wire freq_above_flag,
  input wire freq_below_flag,
  input wire low_duty_flag,
  input wire freq_cycle_done,
  input wire [18:0] slow_result,
  input wire [9:0] fast_result,
  input wire [18:0] aux_result_two,
  input wire [18:0] aux_result_three,
  output wire beeper_on,
  output wire low_ohm_assist,
  output wire acdc_phase_select,
  output wire [3:0] function_select,
  output wire [2:0] range_select,
  output wire [2:0] tone_select,
  output wire [1:0] conv_rate_select,
  output wire [2:0] freq_range_select,
  output wire alt_coupling_enable,
  output wire outside_source_sel,
  output wire adapter_scale_or_duty_aux,
  output wire [1:0] filter_bw_select,
  output wire input_res_ctrl,
  output wire [1:0] amp_config,
  output wire adapter_input_mode
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_WR = 3'h2;
  localparam ST_RD = 3'h3;
  localparam ST_SKIP = 3'h4;

  // places bit 0 of the value at the top so the stream leaves LSB first
  function [18:0] lsb_first;
    input [18:0] v;
    integer i;
    begin
      for (i = 0; i < 19; i = i + 1) begin
        lsb_first[18-i] = v[i];
      end
    end
  endfunction

  function slow_paced;
    input [3:0] fn;
    begin
      slow_paced = (fn == `MSCP_FN_ACV_HZ) || (fn == `MSCP_FN_ACA_HZ) ||
                   (fn == `MSCP_FN_F_DUTY) || (fn == `MSCP_FN_CAP) ||
                   (fn == `MSCP_FN_ADP_HZ);
    end
  endfunction

  reg [2:0] scl_sync_q;
  reg [2:0] sda_sync_q;
  reg scl_q;
  reg scl_p_q;
  reg sda_q;
  reg sda_p_q;
  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [3:0] byte_q;
  reg [6:0] sh_q;
  reg [7:0] tx_q;
  reg sda_oe_q;
  reg sda_out_q;
  reg rd_go_q;
  reg ready_q;
  reg beep_q;
  reg [7:0] stg1_q;
  reg [7:0] stg2_q;
  reg [7:0] stg3_q;
  reg [7:0] c1_q;
  reg [7:0] c2_q;
  reg [7:0] c3_q;
  reg [7:0] c4_q;
  reg [79:0] frame_q;
  reg load_act_q;
  reg [3:0] load_cnt_q;

  wire rise;
  wire fall;
  wire start_evt;
  wire stop_evt;
  wire [7:0] rx_byte;
  wire conv_evt;
  wire [18:0] slow_rev;
  wire [18:0] fast_rev;
  wire [79:0] frame_d;
  wire [7:0] load_byte;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire send_slot;
  wire pop_byte;
  wire [7:0] next_tx;

  // three-stage synchronisers; a level counts once stages two and three agree
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], serial_clk_i};
      sda_sync_q <= {sda_sync_q[1:0], serial_io_line_i};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end

  assign rise = scl_q & ~scl_p_q;
  assign fall = ~scl_q & scl_p_q;
  assign start_evt = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign stop_evt = scl_q & scl_p_q & ~sda_p_q & sda_q;
  assign rx_byte = {sh_q, sda_q};

  // result frame, bytes one to ten from the top down
  assign slow_rev = lsb_first(slow_result);
  assign fast_rev = lsb_first({9'h000, fast_result});
  assign frame_d = {slow_sign, fast_sign, 2'b00, battery_level[0], battery_level[1],
                    divider_ind_low, alarm_flag,
                    freq_above_flag, freq_below_flag, low_duty_flag,
                    divider_ind_high, freq_cycle_done, slow_rev[18:16],
                    slow_rev[15:0],
                    fast_rev[18:9], lsb_first(aux_result_two),
                    lsb_first(aux_result_three)};

  // ready follows fast conversions, or slow and aux3 in counting modes
  assign conv_evt = slow_paced(c1_q[`MSCP_C1_FUNC]) ? (slow_done | aux3_done) :
                    fast_done;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      frame_q <= 80'h0000_0000_0000_0000_0000;
    end else begin
      if (conv_evt) begin
        frame_q <= frame_d;
      end
      // a new conversion in the same cycle as a read keeps ready up
      if (conv_evt) begin
        ready_q <= 1'b1;
      end else if (rd_go_q) begin
        ready_q <= 1'b0;
      end
    end
  end

  // loader refills the fifo at every start so byte one waits at the first read slot
  assign load_byte = frame_q[79 - {load_cnt_q, 3'b000} -: 8];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_act_q <= 1'b0;
      load_cnt_q <= 4'h0;
    end else if (start_evt | stop_evt) begin
      load_act_q <= start_evt;
      load_cnt_q <= 4'h0;
    end else if (load_act_q & fifo_in_ready) begin
      load_cnt_q <= load_cnt_q + 4'h1;
      if (load_cnt_q == `MSCP_RD_BYTES - 4'h1) begin
        load_act_q <= 1'b0;
      end
    end
  end

  mscp_fifo #(
    .W(8),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_txfifo (
    .clock(clock),
    .rst_n(rst_n),
    .flush(start_evt | stop_evt),
    .in_valid(load_act_q),
    .in_ready(fifo_in_ready),
    .in_data(load_byte),
    .out_valid(fifo_out_valid),
    .out_ready(pop_byte),
    .out_data(fifo_out_data)
  );

  // a new byte is taken on the falling clock that opens each read byte
  assign send_slot = fall & (st_q == ST_RD) & (byte_q != `MSCP_RD_BYTES);
  assign pop_byte = send_slot & (bit_q == `MSCP_BIT_FIRST) & fifo_out_valid;
  assign next_tx = (bit_q != `MSCP_BIT_FIRST) ? {tx_q[6:0], 1'b1} :
                   fifo_out_valid ? fifo_out_data : `MSCP_IDLE_BYTE;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
      sh_q <= 7'h00;
      tx_q <= `MSCP_IDLE_BYTE;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
      rd_go_q <= 1'b0;
      beep_q <= 1'b0;
      stg1_q <= `MSCP_CTRL_RST;
      stg2_q <= `MSCP_CTRL_RST;
      stg3_q <= `MSCP_CTRL_RST;
      c1_q <= `MSCP_CTRL_RST;
      c2_q <= `MSCP_CTRL_RST;
      c3_q <= `MSCP_CTRL_RST;
      c4_q <= `MSCP_CTRL_RST;
    end else begin
      rd_go_q <= 1'b0;
      if (start_evt) begin
        // a start aborts any frame, so a write address is taken at any time
        st_q <= ST_ADDR;
        bit_q <= 3'h0;
        byte_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_evt) begin
        // an unfinished write leaves the applied controls untouched
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        if (rise && (st_q != ST_IDLE)) begin
          sh_q <= rx_byte[6:0];
          bit_q <= bit_q + 3'h1;
          if (bit_q == `MSCP_BIT_LAST) begin
            case (st_q)
              ST_ADDR: begin
                if (rx_byte[`MSCP_ID_HDR_RNG] == `MSCP_ID_HDR) begin
                  beep_q <= rx_byte[`MSCP_ID_BEEP];
                  if (rx_byte[`MSCP_ID_DIR] == `MSCP_DIR_READ) begin
                    st_q <= ST_RD;
                    rd_go_q <= 1'b1;
                  end else begin
                    st_q <= ST_WR;
                  end
                end else begin
                  st_q <= ST_SKIP;
                end
              end
              ST_WR: begin
                byte_q <= byte_q + 4'h1;
                case (byte_q)
                  4'h0: begin
                    stg1_q <= rx_byte;
                  end
                  4'h1: begin
                    stg2_q <= rx_byte;
                  end
                  4'h2: begin
                    stg3_q <= rx_byte;
                  end
                  default: begin
                    c1_q <= stg1_q;
                    c2_q <= stg2_q;
                    c3_q <= stg3_q;
                    c4_q <= rx_byte;
                    st_q <= ST_SKIP;
                  end
                endcase
              end
              ST_RD: begin
                if (byte_q != `MSCP_RD_BYTES) begin
                  byte_q <= byte_q + 4'h1;
                end
              end
              default: begin
                st_q <= st_q;
              end
            endcase
          end
        end
        // device bits change only on falling clock, MSB first, open drain
        if (fall && (st_q == ST_RD)) begin
          if (send_slot) begin
            tx_q <= next_tx;
            sda_oe_q <= ~next_tx[`MSCP_BYTE_TOP];
          end else begin
            sda_oe_q <= 1'b0;
          end
        end
      end
    end
  end

  assign serial_io_line_o = sda_out_q;
  assign serial_io_line_oe = sda_oe_q;
  assign result_ready = ready_q;
  assign beeper_on = beep_q;

  assign low_ohm_assist = c1_q[`MSCP_C1_ASSIST];
  assign acdc_phase_select = c1_q[`MSCP_C1_ASSIST];
  assign function_select = c1_q[`MSCP_C1_FUNC];
  assign range_select = c1_q[`MSCP_C1_RANGE];
  assign tone_select = {c2_q[`MSCP_C2_TONE2], c2_q[`MSCP_C2_TONE1], c2_q[`MSCP_C2_TONE0]};
  assign conv_rate_select = {c2_q[`MSCP_C2_RATE1], c2_q[`MSCP_C2_RATE0]};
  assign freq_range_select = c2_q[`MSCP_C2_FREQ];
  assign alt_coupling_enable = c3_q[`MSCP_C3_AC];
  assign outside_source_sel = c3_q[`MSCP_C3_OUTSIDE];
  assign adapter_scale_or_duty_aux = c3_q[`MSCP_C3_AUX];
  assign filter_bw_select = c3_q[`MSCP_C3_FILTER];
  assign input_res_ctrl = c3_q[`MSCP_C3_RES];
  assign amp_config = {c4_q[`MSCP_C4_AMP1], c4_q[`MSCP_C4_AMP0]};
  assign adapter_input_mode = c4_q[`MSCP_C4_ADAPT];

endmodule

`default_nettype wire

// ==== rtl/mscp_regs.vh ====
`ifndef MSCP_REGS_VH
`define MSCP_REGS_VH

// address byte
`define MSCP_ID_HDR 6'h32
`define MSCP_ID_HDR_RNG 7:2
`define MSCP_ID_BEEP 1
`define MSCP_ID_DIR 0
`define MSCP_DIR_READ 1'b1

// frame lengths and bit counting
`define MSCP_WR_LAST 4'h3
`define MSCP_RD_BYTES 4'hA
`define MSCP_BIT_LAST 3'h7
`define MSCP_BIT_FIRST 3'h0
`define MSCP_IDLE_BYTE 8'hFF
`define MSCP_BYTE_TOP 7

// control byte one
`define MSCP_C1_ASSIST 7
`define MSCP_C1_FUNC 6:3
`define MSCP_C1_RANGE 2:0
// control byte two (tone and rate fields sit bit reversed)
`define MSCP_C2_TONE0 7
`define MSCP_C2_TONE1 6
`define MSCP_C2_TONE2 5
`define MSCP_C2_RATE0 4
`define MSCP_C2_RATE1 3
`define MSCP_C2_FREQ 2:0
// control byte three
`define MSCP_C3_AC 7
`define MSCP_C3_OUTSIDE 4
`define MSCP_C3_AUX 3
`define MSCP_C3_FILTER 2:1
`define MSCP_C3_RES 0
// control byte four
`define MSCP_C4_AMP0 2
`define MSCP_C4_AMP1 1
`define MSCP_C4_ADAPT 0

// function codes whose ready follows slow or third auxiliary result
`define MSCP_FN_ACV_HZ 4'h1
`define MSCP_FN_ACA_HZ 4'h3
`define MSCP_FN_F_DUTY 4'h7
`define MSCP_FN_CAP 4'h8
`define MSCP_FN_ADP_HZ 4'hA

`define MSCP_CTRL_RST 8'h00

`endif

// ==== rtl/mscp_fifo.v ====
`timescale 1ns/100ps
`default_nettype none

module mscp_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != D[AW:0]);
  assign push = in_valid & in_ready;
  // prefetch into the output register whenever it is free or being taken
  assign pop = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  always @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end else if (flush) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_q];
        rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule

`default_nettype wire

// ==== tb/mscp_port_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module mscp_port_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clk_i,
  input wire logic serial_io_line_i,
  input wire logic serial_io_line_o,
  input wire logic serial_io_line_oe,
  input wire logic result_ready,
  input wire logic fast_done,
  input wire logic slow_done,
  input wire logic aux3_done,
  input wire logic beeper_on,
  input wire logic low_ohm_assist,
  input wire logic acdc_phase_select,
  input wire logic [3:0] function_select,
  input wire logic [2:0] range_select,
  input wire logic [2:0] tone_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic freq_fn;
  logic [4:0] quiet_q;
  logic scl_q;
  logic sda_q;
  assign freq_fn = function_select inside {4'h1, 4'h3, 4'h7, 4'h8, 4'ha};
  // cycles since either serial pin last moved, saturating
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      quiet_q <= 5'h1f;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= serial_clk_i;
      sda_q <= serial_io_line_i;
      if (scl_q != serial_clk_i || sda_q != serial_io_line_i) begin
        quiet_q <= 5'h00;
      end else if (quiet_q != 5'h1f) begin
        quiet_q <= quiet_q + 5'h01;
      end
    end
  end
  property p_od_low; serial_io_line_o == 1'b0; endproperty
  a_od_low: assert property (p_od_low) else $error("data driven high");
  property p_ready_fast; fast_done && !freq_fn |=> result_ready; endproperty
  a_ready_fast: assert property (p_ready_fast) else $error("no ready on fast");
  property p_ready_freq; (slow_done || aux3_done) && freq_fn |=> result_ready; endproperty
  a_ready_freq: assert property (p_ready_freq) else $error("no ready on slow");
  property p_ready_cause;
    $rose(result_ready) |->
      ($past(freq_fn) ? ($past(slow_done) || $past(aux3_done)) : $past(fast_done));
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without cause");
  property p_ready_hold; result_ready && quiet_q > 5'h10 |=> result_ready; endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped idle");
  property p_ready_low; !result_ready && !(fast_done || slow_done || aux3_done) |=> !result_ready;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready rose early");
  property p_pull_clk_low; $rose(serial_io_line_oe) |-> !serial_clk_i; endproperty
  a_pull_clk_low: assert property (p_pull_clk_low) else $error("pull with clock high");
  property p_idle_release; quiet_q > 5'h10 |-> !serial_io_line_oe; endproperty
  a_idle_release: assert property (p_idle_release) else $error("line held idle");
  property p_ctrl_quiet;
    quiet_q > 5'h10 |=> $stable({function_select, range_select, tone_select, beeper_on});
  endproperty
  a_ctrl_quiet: assert property (p_ctrl_quiet) else $error("control moved idle");
  property p_assist_pair; low_ohm_assist == acdc_phase_select; endproperty
  a_assist_pair: assert property (p_assist_pair) else $error("assist split");
endmodule
bind mscp_port mscp_port_sva u_sva (.clock(clock), .rst_n(rst_n), .serial_clk_i(serial_clk_i),
  .serial_io_line_i(serial_io_line_i), .serial_io_line_o(serial_io_line_o),
  .serial_io_line_oe(serial_io_line_oe), .result_ready(result_ready), .fast_done(fast_done),
  .slow_done(slow_done), .aux3_done(aux3_done), .beeper_on(beeper_on),
  .low_ohm_assist(low_ohm_assist), .acdc_phase_select(acdc_phase_select),
  .function_select(function_select), .range_select(range_select), .tone_select(tone_select));
`default_nettype wire

// ==== tb/mscp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module mscp_host (
  input wire logic clock,
  input wire logic dev_o,
  input wire logic dev_oe,
  output logic scl,
  output wire logic sda
);
  logic pull_q = 1'b0;
  // either side only pulls low; the pull-up wins otherwise
  assign sda = !(pull_q || (dev_oe && !dev_o));
  initial scl = 1'b1;
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  // low phase long enough for the device to answer, sampled late in high phase
  task automatic put_bit(input logic b, output logic seen);
    scl = 1'b0;
    wait_n(3);
    pull_q = !b;
    wait_n(3);
    scl = 1'b1;
    wait_n(2);
    seen = sda;
  endtask
  task automatic put_byte(input logic [7:0] v, output logic [7:0] got);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
      got[i] = s;
    end
  endtask
  task automatic frame(input logic [7:0] addr, input int n, input logic [31:0] w,
                       output logic [79:0] r);
    logic [7:0] g;
    pull_q = 1'b1;
    wait_n(4);
    put_byte(addr, g);
    for (int k = 0; k < n; k++) begin
      put_byte(addr[0] ? 8'hff : w[31-8*k -: 8], g);
      r[79-8*k -: 8] = g;
    end
    scl = 1'b0;
    wait_n(3);
    pull_q = 1'b1;
    wait_n(3);
    scl = 1'b1;
    wait_n(3);
    pull_q = 1'b0;
    wait_n(8);
  endtask
endmodule
`default_nettype wire

// ==== tb/test_meter_serial_command_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mscp_regs.vh"
module test_meter_serial_command_port;
  localparam logic [31:0] w_a = 32'hb59a_8b05;
  localparam logic [31:0] w_b = 32'h4a65_1402;
  localparam logic [10:0] fl_a = 11'h5e6;
  localparam logic [66:0] rs_a = 67'h5_a3c1_0f96_d2e7_4b18;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] done = 3'h0;
  logic [10:0] flags = fl_a;
  logic [66:0] res = rs_a;
  logic [66:0] rv;
  logic [79:0] rx;
  logic frq;
  int n_mismatch = 0;
  int n_compared = 0;
  wire logic scl;
  wire logic sda;
  wire logic dev_o;
  wire logic dev_oe;
  wire logic result_ready;
  wire logic beeper_on;
  wire logic [25:0] ctl;
  always #25 clock = ~clock;
  mscp_port uut (.clock(clock), .rst_n(rst_n), .serial_clk_i(scl), .serial_io_line_i(sda),
    .serial_io_line_o(dev_o), .serial_io_line_oe(dev_oe), .result_ready(result_ready),
    .fast_done(done[0]), .slow_done(done[1]), .aux3_done(done[2]), .slow_sign(flags[10]),
    .fast_sign(flags[9]), .battery_level(flags[8:7]), .divider_ind_low(flags[6]),
    .alarm_flag(flags[5]), .freq_above_flag(flags[4]), .freq_below_flag(flags[3]),
    .low_duty_flag(flags[2]), .divider_ind_high(flags[1]), .freq_cycle_done(flags[0]),
    .slow_result(res[18:0]), .fast_result(res[28:19]), .aux_result_two(res[47:29]),
    .aux_result_three(res[66:48]), .beeper_on(beeper_on), .low_ohm_assist(ctl[25]),
    .acdc_phase_select(ctl[24]), .function_select(ctl[23:20]), .range_select(ctl[19:17]),
    .tone_select(ctl[16:14]), .conv_rate_select(ctl[13:12]), .freq_range_select(ctl[11:9]),
    .alt_coupling_enable(ctl[8]), .outside_source_sel(ctl[7]),
    .adapter_scale_or_duty_aux(ctl[6]), .filter_bw_select(ctl[5:4]),
    .input_res_ctrl(ctl[3]), .amp_config(ctl[2:1]), .adapter_input_mode(ctl[0]));
  mscp_host host (.clock(clock), .dev_o(dev_o), .dev_oe(dev_oe), .scl(scl), .sda(sda));
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // control outputs expected from the four written bytes
  function automatic logic [25:0] exp_ctl(input logic [31:0] w);
    return {w[31], w[31], w[30:24], w[21], w[22], w[23], w[19], w[20], w[18:16],
            w[15], w[12], w[11], w[10:9], w[8], w[1], w[2], w[0]};
  endfunction
  task automatic pulse(input logic [2:0] d);
    done = d;
    host.wait_n(1);
    done = 3'h0;
    host.wait_n(2);
  endtask
  initial begin
    host.wait_n(12);
    rst_n = 1'b1;
    check("ready", result_ready, 0);
    host.wait_n(6);
    host.frame({`MSCP_ID_HDR, 2'b10}, 4, w_a, rx);
    check("ctl", ctl, exp_ctl(w_a));
    check("beep", beeper_on, 1);
    host.frame({`MSCP_ID_HDR, 2'b00}, 2, w_b, rx);
    check("ctl", ctl, exp_ctl(w_a));
    host.frame({`MSCP_ID_HDR, 2'b10}, 0, w_b, rx);
    check("ctl", ctl, exp_ctl(w_a));
    check("beep", beeper_on, 1);
    host.frame({6'h33, 2'b00}, 4, w_b, rx);
    check("ctl", ctl, exp_ctl(w_a));
    check("beep", beeper_on, 1);
    host.frame({`MSCP_ID_HDR, 2'b00}, 4, w_b, rx);
    check("ctl", ctl, exp_ctl(w_b));
    check("beep", beeper_on, 0);
    for (int i = 0; i < 2; i++) begin
      flags = i ? ~fl_a : fl_a;
      res = i ? ~rs_a : rs_a;
      rv = {<<{res}};
      repeat (10) pulse(3'h1);
      check("ready", result_ready, 1);
      host.wait_n(40);
      check("ready", result_ready, 1);
      host.frame({`MSCP_ID_HDR, 2'b01}, 10, 32'h0000_0000, rx);
      check("ready", result_ready, 0);
      check("frame", {rx[79:78], 2'b00, rx[75:0]},
            {flags[10:9], 2'b00, flags[7], flags[8], flags[6:0], rv});
    end
    for (int f = 0; f < 11; f++) begin
      frq = f inside {1, 3, 7, 8, 10};
      host.frame({`MSCP_ID_HDR, 2'b00}, 4, {1'b0, f[3:0], 27'h000_0000}, rx);
      host.frame({`MSCP_ID_HDR, 2'b01}, 10, 32'h0000_0000, rx);
      pulse(3'h1);
      check("ready fast", result_ready, !frq);
      host.frame({`MSCP_ID_HDR, 2'b01}, 10, 32'h0000_0000, rx);
      pulse(f[0] ? 3'h2 : 3'h4);
      check("ready slow", result_ready, frq);
    end
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
